// ===== test/din_switches.sv
`default_nettype none
module din_switches
(
  input wire logic clk,
  input wire logic [6:0] contact,
  output logic [6:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // Contact high means switch closed; limit switches sit closed while clear of the end stop
  initial pins = 7'h00;
  always @(posedge clk)
  begin
    pins <= contact;
  end
endmodule
`default_nettype wire

// ===== test/tb_din_decoder.sv
`default_nettype none
module tb_din_decoder
  import din_decode_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic MCLK = 1'b0;
  logic RST_N = 1'b0;
  logic ALARM_IN = 1'b0;
  logic HSEL = 1'b0;
  logic HWRITE = 1'b0;
  logic [1:0] HTRANS = 2'b00;
  logic [2:0] HSIZE = 3'h2;
  logic [31:0] HADDR = 32'h0000_0000;
  logic [31:0] HWDATA = 32'h0000_0000;
  logic [31:0] HRDATA, rd;
  logic [6:0] contact = 7'h30;
  logic [6:0] DIN;
  logic HREADYOUT, HRESP, DRIVE_ENABLE, ALARM_PENDING, FAULT_CLEAR, P_ONLY, FWD_INHIBIT, REV_INHIBIT;
  logic HOME_SENSOR, SPEED_REVERSE, HOMING_START, POS_ACTIVATE;
  logic [7:0] OP_MODE;
  logic [2:0] SPEED_SEL, POS_SEL, GEAR_SEL;
  logic [1:0] GAIN_SEL;
  int errors = 0;
  int checks = 0;
  int fc = 0;
  int hs = 0;
  int pa = 0;
  logic [15:0] sel_codes [11] = '{FN_SPEED_SEL0, FN_SPEED_SEL1, FN_SPEED_SEL2, FN_POS_SEL0, FN_POS_SEL1,
    FN_POS_SEL2, FN_GEAR_SEL0, FN_GEAR_SEL1, FN_GEAR_SEL2, FN_GAIN_SEL0, FN_GAIN_SEL1};

  din_switches din_switches_inst (.clk(MCLK), .contact(contact), .pins(DIN));
  din_decoder din_decoder_inst (.MCLK(MCLK), .RST_N(RST_N), .DIN(DIN), .ALARM_IN(ALARM_IN), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .DRIVE_ENABLE(DRIVE_ENABLE),
    .ALARM_PENDING(ALARM_PENDING), .FAULT_CLEAR(FAULT_CLEAR), .OP_MODE(OP_MODE), .P_ONLY(P_ONLY),
    .FWD_INHIBIT(FWD_INHIBIT), .REV_INHIBIT(REV_INHIBIT), .HOME_SENSOR(HOME_SENSOR),
    .SPEED_REVERSE(SPEED_REVERSE), .SPEED_SEL(SPEED_SEL), .POS_SEL(POS_SEL), .GEAR_SEL(GEAR_SEL),
    .GAIN_SEL(GAIN_SEL), .HOMING_START(HOMING_START), .POS_ACTIVATE(POS_ACTIVATE));

  initial
  begin
    forever #4 MCLK = ~MCLK;
  end

  // Pulses are counted per cycle, so a stretched pulse shows up as an extra count
  always @(posedge MCLK)
  begin
    if (FAULT_CLEAR === 1'b1)
      fc <= fc + 1;
    if (HOMING_START === 1'b1)
      hs <= hs + 1;
    if (POS_ACTIVATE === 1'b1)
      pa <= pa + 1;
  end

  task automatic give_verdict();
    if (errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    do
    begin
      @(posedge MCLK);
      n++;
    end
    while (HREADYOUT !== 1'b1 && n < 50);
    if (HREADYOUT !== 1'b1)
    begin
      errors++;
      give_verdict();
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    HSEL <= 1'b1;
    HTRANS <= 2'b10;
    HADDR <= 32'(a);
    HWRITE <= wr;
    wait_ready();
    HSEL <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= wd;
    wait_ready();
    rd = HRDATA;
    cmp(32'(HRESP), 32'h0000_0000);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0000_0000);
    cmp(rd, exp);
  endtask

  // Switch register, two sync stages, output stage, plus two edges so the pulse counters have counted and settled
  task automatic pins_for(input logic [6:0] v);
    contact <= v;
    repeat (6) @(posedge MCLK);
  endtask

  task automatic t_regs();
    rdchk(OFS_FSEL_BASE, 32'h0000_0001);
    rdchk(8'h18, 32'h0000_0040);
    rdchk(OFS_POLARITY, 32'h0000_007F);
    rdchk(OFS_CTRL, 32'h0000_0006);
    wr(8'h3C, 32'hFFFF_FFFF);
    rdchk(8'h3C, 32'h0000_0000);
  endtask

  task automatic t_enable_limits();
    pins_for(7'h30);
    cmp(32'({DRIVE_ENABLE, FWD_INHIBIT, REV_INHIBIT}), 32'h0000_0000);
    pins_for(7'h31);
    cmp(32'(DRIVE_ENABLE), 32'h0000_0001);
    pins_for(7'h21);
    cmp(32'({FWD_INHIBIT, REV_INHIBIT}), 32'h0000_0002);
    pins_for(7'h11);
    cmp(32'({FWD_INHIBIT, REV_INHIBIT}), 32'h0000_0001);
    wr(OFS_CTRL, 32'h0000_0000);
    pins_for(7'h01);
    cmp(32'({FWD_INHIBIT, REV_INHIBIT}), 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_0006);
    pins_for(7'h31);
  endtask

  task automatic t_fault();
    int f0;
    ALARM_IN <= 1'b1;
    @(posedge MCLK);
    ALARM_IN <= 1'b0;
    repeat (2) @(posedge MCLK);
    cmp(32'(ALARM_PENDING), 32'h0000_0001);
    f0 = fc;
    pins_for(7'h33);
    repeat (6) @(posedge MCLK);
    cmp(32'(ALARM_PENDING), 32'h0000_0000);
    cmp(32'(fc - f0), 32'h0000_0001);
    pins_for(7'h31);
    pins_for(7'h33);
    cmp(32'(fc - f0), 32'h0000_0002);
    pins_for(7'h31);
  endtask

  task automatic t_mode();
    wr(OFS_MODE_INACT, 32'h0000_00FC);
    wr(OFS_MODE_ACT, 32'h0000_00FD);
    pins_for(7'h31);
    cmp(32'(OP_MODE), 32'h0000_00FC);
    pins_for(7'h35);
    cmp(32'(OP_MODE), 32'h0000_00FD);
  endtask

  task automatic t_funcs();
    pins_for(7'h3D);
    cmp(32'(P_ONLY), 32'h0000_0001);
    wr(8'h0C, 32'(FN_DISABLE));
    pins_for(7'h3D);
    cmp(32'({P_ONLY, SPEED_REVERSE, HOME_SENSOR}), 32'h0000_0000);
    wr(8'h0C, 32'(FN_SPEED_REV));
    pins_for(7'h3D);
    cmp(32'(SPEED_REVERSE), 32'h0000_0001);
    wr(8'h0C, 32'(FN_HOME_SENSOR));
    pins_for(7'h3D);
    cmp(32'(HOME_SENSOR), 32'h0000_0001);
    for (int k = 0; k < 11; k++)
    begin
      wr(8'h0C, 32'(sel_codes[k]));
      pins_for(7'h3D);
      cmp(32'({GAIN_SEL, GEAR_SEL, POS_SEL, SPEED_SEL}), 32'h0000_0001 << k);
    end
    rdchk(OFS_FN_STATUS, 32'h0000_8001);
    pins_for(7'h31);
  endtask

  task automatic t_edges();
    int h0;
    int p0;
    h0 = hs;
    p0 = pa;
    wr(8'h0C, 32'(FN_START_HOME));
    pins_for(7'h39);
    pins_for(7'h31);
    cmp(32'(hs - h0), 32'h0000_0001);
    wr(8'h0C, 32'(FN_ACTIVATE));
    pins_for(7'h39);
    pins_for(7'h39);
    cmp(32'({16'(hs - h0), 16'(pa - p0)}), 32'h0001_0001);
  endtask

  task automatic t_qstop();
    pins_for(7'h31);
    wr(8'h0C, 32'(FN_QUICK_STOP));
    pins_for(7'h39);
    cmp(32'(DRIVE_ENABLE), 32'h0000_0000);
    pins_for(7'h31);
    cmp(32'(DRIVE_ENABLE), 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_000E);
    pins_for(7'h31);
    cmp(32'(DRIVE_ENABLE), 32'h0000_0001);
    pins_for(7'h39);
    pins_for(7'h31);
    cmp(32'(DRIVE_ENABLE), 32'h0000_0000);
    pins_for(7'h30);
    pins_for(7'h31);
    cmp(32'(DRIVE_ENABLE), 32'h0000_0001);
  endtask

  task automatic t_auto();
    wr(8'h18, 32'(FN_ENABLE));
    wr(OFS_FSEL_BASE, 32'(FN_DISABLE));
    pins_for(7'h31);
    cmp(32'(DRIVE_ENABLE), 32'h0000_0000);
    pins_for(7'h70);
    cmp(32'(DRIVE_ENABLE), 32'h0000_0001);
    wr(8'h18, 32'(FN_DISABLE));
    wr(OFS_CTRL, 32'h0000_0007);
    pins_for(7'h30);
    cmp(32'(DRIVE_ENABLE), 32'h0000_0001);
    wr(OFS_CTRL, 32'h0000_0006);
    pins_for(7'h30);
    cmp(32'(DRIVE_ENABLE), 32'h0000_0000);
    for (int i = 1; i < 6; i++)
      wr(8'(4 * i), 32'(FN_DISABLE));
    pins_for(7'h7F);
    cmp(32'({DRIVE_ENABLE, P_ONLY, SPEED_REVERSE, HOME_SENSOR, FWD_INHIBIT, REV_INHIBIT}), 32'h0000_0003);
  endtask

  initial
  begin
    repeat (20000) @(posedge MCLK);
    errors++;
    give_verdict();
  end

  initial
  begin
    repeat (6) @(posedge MCLK);
    RST_N <= 1'b1;
    @(posedge MCLK);
    t_regs();
    t_enable_limits();
    t_fault();
    t_mode();
    t_funcs();
    t_edges();
    t_qstop();
    t_auto();
    give_verdict();
  end
endmodule
`default_nettype wire

// ===== verilog/din_condition.sv
`default_nettype none
module din_condition
  import din_decode_pkg::*;
#(
  parameter int WIDTH = 7
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pins,
  input wire logic [WIDTH-1:0] active_high,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] valid
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // Two-stage synchroniser per input, then polarity
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : gen_bit
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          meta_reg[g] <= 1'b0;
          sync_reg[g] <= 1'b0;
        end
        else
        begin
          meta_reg[g] <= pins[g];
          sync_reg[g] <= meta_reg[g];
        end
      end
      assign level[g] = sync_reg[g];
      assign valid[g] = active_high[g] ? sync_reg[g] : ~sync_reg[g];
    end
  endgenerate
endmodule
`default_nettype wire

// ===== verilog/din_decode_pkg.sv
`default_nettype none
package din_decode_pkg;
  localparam int NUM_INPUTS = 7;
  localparam int FSEL_W = 16;

  // Function codes written into each input's function select; one-hot except the zero disable code and the bit 15 codes
  localparam logic [15:0] FN_DISABLE = 16'h0000;
  localparam logic [15:0] FN_ENABLE = 16'h0001;
  localparam logic [15:0] FN_FAULT_RST = 16'h0002;
  localparam logic [15:0] FN_MODE_CTRL = 16'h0004;
  localparam logic [15:0] FN_P_ONLY = 16'h0008;
  localparam logic [15:0] FN_LIM_POS = 16'h0010;
  localparam logic [15:0] FN_LIM_NEG = 16'h0020;
  localparam logic [15:0] FN_HOME_SENSOR = 16'h0040;
  localparam logic [15:0] FN_SPEED_REV = 16'h0080;
  localparam logic [15:0] FN_SPEED_SEL0 = 16'h0100;
  localparam logic [15:0] FN_SPEED_SEL1 = 16'h0200;
  localparam logic [15:0] FN_SPEED_SEL2 = 16'h8001;
  localparam logic [15:0] FN_POS_SEL0 = 16'h0400;
  localparam logic [15:0] FN_POS_SEL1 = 16'h0800;
  localparam logic [15:0] FN_POS_SEL2 = 16'h8002;
  localparam logic [15:0] FN_GEAR_SEL0 = 16'h8004;
  localparam logic [15:0] FN_GEAR_SEL1 = 16'h8008;
  localparam logic [15:0] FN_GEAR_SEL2 = 16'h8010;
  localparam logic [15:0] FN_GAIN_SEL0 = 16'h8020;
  localparam logic [15:0] FN_GAIN_SEL1 = 16'h8040;
  localparam logic [15:0] FN_QUICK_STOP = 16'h1000;
  localparam logic [15:0] FN_START_HOME = 16'h2000;
  localparam logic [15:0] FN_ACTIVATE = 16'h4000;

  // Register byte offsets
  localparam logic [7:0] OFS_FSEL_BASE = 8'h00;
  localparam logic [7:0] OFS_POLARITY = 8'h1C;
  localparam logic [7:0] OFS_MODE_INACT = 8'h20;
  localparam logic [7:0] OFS_MODE_ACT = 8'h24;
  localparam logic [7:0] OFS_CTRL = 8'h28;
  localparam logic [7:0] OFS_PIN_STATUS = 8'h2C;
  localparam logic [7:0] OFS_FN_STATUS = 8'h30;

  // Control register fields
  localparam int CTRL_AUTO_ON = 0;
  localparam int CTRL_POS_NC = 1;
  localparam int CTRL_NEG_NC = 2;
  localparam int CTRL_REENABLE = 3;

  // Reset values
  localparam logic [6:0][15:0] FSEL_RST = {16'h0040, 16'h0020, 16'h0010, 16'h0008,
                                           16'h0004, 16'h0002, 16'h0001};
  localparam logic [6:0] POLARITY_RST = 7'h7F;
  localparam logic [2:0] CTRL_RST = 3'h6;
  localparam logic [7:0] MODE_RST = 8'h00;
endpackage
`default_nettype wire

// ===== verilog/din_decoder.sv
// Function
// - An input set to the disable code drives no function at any level.
// - A valid drive-enable input enables the drive and locks the shaft.
// - Fault reset acts on its rising edge only and clears pending alarms.
// - Mode input picks mode_when_active when valid, mode_when_inactive otherwise.
// - Valid proportional-only input stops velocity loop integration.
// - Positive limit inhibits forward motion; normally closed by default, polarity settable.
// - Negative limit inhibits reverse motion; normally closed by default, polarity settable.
// - Homing signal input serves as origin sensor during homing.
// - Valid reverse speed input negates the target speed in speed modes.
// - Three speed select inputs choose one stored internal speed.
// - Three position select inputs choose one stored internal position.
// - Gear select inputs choose one stored electronic gear ratio set.
// - Two gain select inputs choose one stored loop gain set.
// - Quick stop releases the shaft; drive stays off until enabled again.
// - Rising edge of start homing input starts a homing command.
// - Rising edge of activate input activates the selected internal position.
// - Any input becomes drive enable when its function select holds bit 0 code.
// - No input assigned enable and auto power-on set: drive enables itself.
// - Each function select holds one code naming one function; the codes with bit 15 set have two bits set.
`default_nettype none
module din_decoder
  import din_decode_pkg::*;
#(
  parameter int N = NUM_INPUTS
)
(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic [N-1:0] DIN,
  input wire logic ALARM_IN,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  output logic DRIVE_ENABLE,
  output logic ALARM_PENDING,
  output logic FAULT_CLEAR,
  output logic [7:0] OP_MODE,
  output logic P_ONLY,
  output logic FWD_INHIBIT,
  output logic REV_INHIBIT,
  output logic HOME_SENSOR,
  output logic SPEED_REVERSE,
  output logic [2:0] SPEED_SEL,
  output logic [2:0] POS_SEL,
  output logic [2:0] GEAR_SEL,
  output logic [1:0] GAIN_SEL,
  output logic HOMING_START,
  output logic POS_ACTIVATE
);
  logic [N-1:0] pin_level;
  logic [N-1:0] pin_valid;
  logic [15:0] fsel_reg [N];
  logic [15:0] fsel_next [N];
  logic [N-1:0] pol_reg, pol_next;
  logic [7:0] mode0_reg, mode0_next, mode1_reg, mode1_next;
  logic [2:0] ctrl_reg, ctrl_next;
  logic reenable_wr;
  logic [7:0] addr_ph_reg, addr_ph_next;
  logic wr_ph_reg, wr_ph_next;
  logic [31:0] rdata_next;
  logic [3:0] edge_lvl, edge_rise;
  logic en_on, en_assigned, enable_req, qs_on, mode_on, limpos_on, limneg_on;
  logic qs_latch_reg, qs_latch_next;
  logic drive_next, alarm_next;
  logic [31:0] fn_status;

  din_condition #(.WIDTH(N)) u_cond (
    .clk(MCLK),
    .rst_n(RST_N),
    .pins(DIN),
    .active_high(pol_reg),
    .level(pin_level),
    .valid(pin_valid)
  );

  // An input carries a function only if its select equals that exact code
  function automatic logic fn_on(input logic [15:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < N; i++)
      if (code != FN_DISABLE && fsel_reg[i] == code && pin_valid[i])
        hit = 1'b1;
    return hit;
  endfunction

  function automatic logic fn_assigned(input logic [15:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < N; i++)
      if (fsel_reg[i] == code)
        hit = 1'b1;
    return hit;
  endfunction

  always_comb
  begin
    en_on = fn_on(FN_ENABLE);
    en_assigned = fn_assigned(FN_ENABLE);
    enable_req = en_assigned ? en_on : ctrl_reg[CTRL_AUTO_ON];
    qs_on = fn_on(FN_QUICK_STOP);
    mode_on = fn_on(FN_MODE_CTRL);
    limpos_on = fn_on(FN_LIM_POS) ^ ctrl_reg[CTRL_POS_NC];
    limneg_on = fn_on(FN_LIM_NEG) ^ ctrl_reg[CTRL_NEG_NC];
    edge_lvl = {enable_req, fn_on(FN_ACTIVATE), fn_on(FN_START_HOME), fn_on(FN_FAULT_RST)};
  end

  rise_detect #(.WIDTH(4)) u_edges (
    .clk(MCLK),
    .rst_n(RST_N),
    .level(edge_lvl),
    .rise(edge_rise)
  );

  // Drive enable and quick-stop latch
  always_comb
  begin
    qs_latch_next = qs_latch_reg;
    if (qs_on)
      qs_latch_next = 1'b1;
    else if (edge_rise[3] || reenable_wr)
      qs_latch_next = 1'b0;
    drive_next = enable_req && !qs_on && !qs_latch_next;
    // A new alarm in the clearing cycle stays pending
    alarm_next = ALARM_IN || (ALARM_PENDING && !edge_rise[0]);
  end

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      qs_latch_reg <= 1'b0;
      DRIVE_ENABLE <= 1'b0;
      ALARM_PENDING <= 1'b0;
      FAULT_CLEAR <= 1'b0;
      OP_MODE <= MODE_RST;
      P_ONLY <= 1'b0;
      FWD_INHIBIT <= 1'b0;
      REV_INHIBIT <= 1'b0;
      HOME_SENSOR <= 1'b0;
      SPEED_REVERSE <= 1'b0;
      SPEED_SEL <= 3'h0;
      POS_SEL <= 3'h0;
      GEAR_SEL <= 3'h0;
      GAIN_SEL <= 2'h0;
      HOMING_START <= 1'b0;
      POS_ACTIVATE <= 1'b0;
    end
    else
    begin
      qs_latch_reg <= qs_latch_next;
      DRIVE_ENABLE <= drive_next;
      ALARM_PENDING <= alarm_next;
      FAULT_CLEAR <= edge_rise[0];
      OP_MODE <= mode_on ? mode1_reg : mode0_reg;
      P_ONLY <= fn_on(FN_P_ONLY);
      FWD_INHIBIT <= limpos_on;
      REV_INHIBIT <= limneg_on;
      HOME_SENSOR <= fn_on(FN_HOME_SENSOR);
      SPEED_REVERSE <= fn_on(FN_SPEED_REV);
      SPEED_SEL <= {fn_on(FN_SPEED_SEL2), fn_on(FN_SPEED_SEL1), fn_on(FN_SPEED_SEL0)};
      POS_SEL <= {fn_on(FN_POS_SEL2), fn_on(FN_POS_SEL1), fn_on(FN_POS_SEL0)};
      GEAR_SEL <= {fn_on(FN_GEAR_SEL2), fn_on(FN_GEAR_SEL1), fn_on(FN_GEAR_SEL0)};
      GAIN_SEL <= {fn_on(FN_GAIN_SEL1), fn_on(FN_GAIN_SEL0)};
      HOMING_START <= edge_rise[1];
      POS_ACTIVATE <= edge_rise[2];
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY
  always_comb
  begin
    addr_ph_next = addr_ph_reg;
    wr_ph_next = 1'b0;
    if (HSEL && HTRANS[1] && HREADY)
    begin
      addr_ph_next = HADDR[7:0];
      wr_ph_next = HWRITE;
    end
  end

  always_comb
  begin
    for (int i = 0; i < N; i++)
      fsel_next[i] = fsel_reg[i];
    pol_next = pol_reg;
    mode0_next = mode0_reg;
    mode1_next = mode1_reg;
    ctrl_next = ctrl_reg;
    reenable_wr = 1'b0;
    if (wr_ph_reg)
    begin
      for (int i = 0; i < N; i++)
        if (addr_ph_reg == OFS_FSEL_BASE + 8'(4 * i))
          fsel_next[i] = HWDATA[15:0];
      if (addr_ph_reg == OFS_POLARITY)
        pol_next = HWDATA[N-1:0];
      if (addr_ph_reg == OFS_MODE_INACT)
        mode0_next = HWDATA[7:0];
      if (addr_ph_reg == OFS_MODE_ACT)
        mode1_next = HWDATA[7:0];
      if (addr_ph_reg == OFS_CTRL)
      begin
        ctrl_next = HWDATA[2:0];
        reenable_wr = HWDATA[CTRL_REENABLE];
      end
    end
  end

  assign fn_status = {16'h0000, GAIN_SEL, GEAR_SEL, POS_SEL, SPEED_SEL, qs_latch_reg,
                      FWD_INHIBIT, REV_INHIBIT, ALARM_PENDING, DRIVE_ENABLE};

  // Read data uses next values so a read right after a write sees it
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    if (HSEL && HTRANS[1] && HREADY && !HWRITE)
    begin
      for (int i = 0; i < N; i++)
        if (HADDR[7:0] == OFS_FSEL_BASE + 8'(4 * i))
          rdata_next = {16'h0000, fsel_next[i]};
      unique case (HADDR[7:0])
        OFS_POLARITY: rdata_next[N-1:0] = pol_next;
        OFS_MODE_INACT: rdata_next[7:0] = mode0_next;
        OFS_MODE_ACT: rdata_next[7:0] = mode1_next;
        OFS_CTRL: rdata_next[2:0] = ctrl_next;
        OFS_PIN_STATUS: rdata_next[N-1:0] = pin_level;
        OFS_FN_STATUS: rdata_next = fn_status;
        default: ;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      for (int i = 0; i < N; i++)
        fsel_reg[i] <= FSEL_RST[i];
      pol_reg <= POLARITY_RST;
      mode0_reg <= MODE_RST;
      mode1_reg <= MODE_RST;
      ctrl_reg <= CTRL_RST;
      addr_ph_reg <= 8'h00;
      wr_ph_reg <= 1'b0;
      HRDATA <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < N; i++)
        fsel_reg[i] <= fsel_next[i];
      pol_reg <= pol_next;
      mode0_reg <= mode0_next;
      mode1_reg <= mode1_next;
      ctrl_reg <= ctrl_next;
      addr_ph_reg <= addr_ph_next;
      wr_ph_reg <= wr_ph_next;
      HRDATA <= rdata_next;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  logic all_disabled;
  always_comb
  begin
    all_disabled = 1'b1;
    for (int i = 0; i < N; i++)
      if (fsel_reg[i] != FN_DISABLE)
        all_disabled = 1'b0;
  end

  // Properties read these nets, so they see sampled values rather than a function's live reads
  logic rev_on, ponly_on, home_on, spd0_on, gain1_on;
  always_comb
  begin
    rev_on = fn_on(FN_SPEED_REV);
    ponly_on = fn_on(FN_P_ONLY);
    home_on = fn_on(FN_HOME_SENSOR);
    spd0_on = fn_on(FN_SPEED_SEL0);
    gain1_on = fn_on(FN_GAIN_SEL1);
  end

  chk_disable_inert: assert property (all_disabled && !ctrl_reg[CTRL_AUTO_ON] && $stable(ctrl_reg)
    |=> !DRIVE_ENABLE && !SPEED_REVERSE && !HOMING_START && SPEED_SEL == 3'h0)
    else $error("disabled inputs changed a function");
  chk_enable_drives: assert property (en_assigned && en_on && !qs_on && !qs_latch_reg
    |=> DRIVE_ENABLE)
    else $error("valid enable input did not enable drive");
  chk_fault_clear_edge: assert property (edge_rise[0] && !ALARM_IN |=> FAULT_CLEAR && !ALARM_PENDING)
    else $error("fault reset edge did not clear alarm");
  chk_alarm_set_wins: assert property (ALARM_IN |=> ALARM_PENDING)
    else $error("alarm lost in clearing cycle");
  chk_mode_select: assert property (##1 OP_MODE == ($past(mode_on) ? $past(mode1_reg) : $past(mode0_reg)))
    else $error("operating mode select wrong");
  chk_fwd_limit: assert property (limpos_on |=> FWD_INHIBIT)
    else $error("forward limit not applied");
  chk_rev_limit: assert property (!limneg_on |=> !REV_INHIBIT)
    else $error("reverse inhibit without limit");
  chk_reverse_speed: assert property (rev_on |=> SPEED_REVERSE)
    else $error("reverse speed not flagged");
  chk_quickstop_hold: assert property (qs_on || (qs_latch_reg && !edge_rise[3] && !reenable_wr)
    |=> !DRIVE_ENABLE)
    else $error("drive re-enabled after quick stop without enable");
  chk_home_once: assert property (HOMING_START |=> !HOMING_START)
    else $error("homing start longer than one cycle");
  chk_activate_edge: assert property (edge_rise[2] |=> POS_ACTIVATE ##1 !POS_ACTIVATE)
    else $error("activate pulse wrong");
  chk_auto_enable: assert property (!en_assigned && ctrl_reg[CTRL_AUTO_ON] && !qs_on && !qs_latch_reg
    |=> DRIVE_ENABLE)
    else $error("auto power-on did not enable drive");
  chk_p_only: assert property (ponly_on |=> P_ONLY)
    else $error("proportional-only input not applied");
  chk_home_sensor: assert property (!home_on |=> !HOME_SENSOR)
    else $error("origin sensor flagged without input");
  chk_speed_select: assert property (spd0_on |=> SPEED_SEL[0])
    else $error("speed select bit not applied");
  chk_gain_select: assert property (gain1_on |=> GAIN_SEL[1])
    else $error("gain select bit not applied");

  cov_quick_stop: cover property (DRIVE_ENABLE ##1 qs_on ##[1:8] !qs_on ##[1:20] DRIVE_ENABLE);
  cov_fault_clear: cover property (ALARM_PENDING ##1 FAULT_CLEAR);
  cov_mode_switch: cover property ($changed(OP_MODE));
  cov_homing_start: cover property (HOMING_START);
  cov_auto_on: cover property (!en_assigned && ctrl_reg[CTRL_AUTO_ON] ##1 DRIVE_ENABLE);
endmodule
`default_nettype wire

// ===== verilog/rise_detect.sv
`default_nettype none
module rise_detect
  import din_decode_pkg::*;
#(
  parameter int WIDTH = 4
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);
  logic [WIDTH-1:0] prev_reg;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : gen_bit
      // Previous starts high so a level already valid at reset is not an edge
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          prev_reg[g] <= 1'b1;
        else
          prev_reg[g] <= level[g];
      end
      assign rise[g] = level[g] & ~prev_reg[g];
    end
  endgenerate
endmodule
`default_nettype wire
